//--- vpe_pkg.sv
// Package for the voltage protection element: settings, types and timing constants.
// Assumes one 100 MHz clock and unsigned magnitude samples from the measuring front end.
package vpe_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int VW = 16;
    localparam int TW = 32;
    localparam int CLK_MHZ = 100;
    localparam int AVG_WINDOW_MIN = 10;
    localparam logic [47:0] AVG_WINDOW_CYC =
        48'(AVG_WINDOW_MIN) * 48'd60 * 48'd1000000 * 48'(CLK_MHZ);
    // Averaging uses 2**AVG_SHIFT sub-samples per window.
    localparam int AVG_SHIFT = 8;
    localparam logic [47:0] AVG_SUB_CYC = AVG_WINDOW_CYC >> AVG_SHIFT;
    // Loss-of-potential threshold is 3/100 of nominal.
    localparam logic [VW-1:0] POT_LOSS_NUM = 16'h0003;
    localparam logic [VW-1:0] POT_LOSS_DEN = 16'h0064;
    // Overvoltage dropout cap 97 percent.
    localparam logic [7:0] OV_DROP_PCT = 8'h61;
    localparam logic [7:0] PCT_FULL = 8'h64;
    // 1/sqrt(3) in Q0.16.
    localparam logic [VW-1:0] INV_SQRT3_Q16 = 16'h93CD;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        VPE_METH_FUND = 2'b00,
        VPE_METH_RMS = 2'b01,
        VPE_METH_AVG = 2'b10
    } vpe_meth_t;

    typedef enum logic {
        VPE_MODE_UNDER = 1'b0,
        VPE_MODE_OVER = 1'b1
    } vpe_mode_t;

    typedef enum logic [1:0] {
        VPE_ANY_ONE = 2'b00,
        VPE_ANY_TWO = 2'b01,
        VPE_ALL_THREE = 2'b10
    } vpe_logic_t;

    typedef enum logic [1:0] {
        VPE_ST_RUN = 2'b00,
        VPE_ST_BLOCKED = 2'b01,
        VPE_ST_DELAY = 2'b10
    } vpe_imin_st_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [VW-1:0] ph3;
        logic [VW-1:0] ph2;
        logic [VW-1:0] ph1;
    } vpe_tri_t;

    typedef struct packed {
        vpe_mode_t mode;
        vpe_meth_t meth;
        logic meas_pp;
        logic wiring_pp;
        vpe_logic_t pick_logic;
        logic [VW-1:0] pickup_pu;
        logic [7:0] dropout_pct;
        logic [TW-1:0] trip_cyc;
        logic imin_en;
        logic [VW-1:0] imin_thr;
        logic [TW-1:0] imin_dly_cyc;
        logic supv_en;
    } vpe_cfg_t;

    typedef struct packed {
        logic [2:0] alarm;
        logic [2:0] trip;
        logic alarm_any;
        logic trip_any;
    } vpe_flags_t;

endpackage

//--- vpe_avg.sv
// Sliding-average filter for one voltage channel.
// Assumes the input is a steady magnitude sample updated every clock.
`timescale 1ns/100ps
module vpe_avg (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [vpe_pkg::VW-1:0] sample,
    output logic [vpe_pkg::VW-1:0] avg
);
    localparam int N = 1 << vpe_pkg::AVG_SHIFT;

    logic [vpe_pkg::VW-1:0] buf_r [N];
    logic [vpe_pkg::AVG_SHIFT-1:0] idx_r;
    logic [47:0] sub_r;
    logic [vpe_pkg::VW+vpe_pkg::AVG_SHIFT-1:0] sum_r;

    // Sub-sample timer; the window slides one slot each sub period.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sub_r <= 48'h0;
        end else if (sub_r >= vpe_pkg::AVG_SUB_CYC - 48'h1) begin
            sub_r <= 48'h0;
        end else begin
            sub_r <= sub_r + 48'h1;
        end
    end

    // Running sum: add the new slot, drop the oldest.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= '0;
            sum_r <= '0;
            for (int i = 0; i < N; i++) begin
                buf_r[i] <= '0;
            end
        end else if (sub_r == 48'h0) begin
            buf_r[idx_r] <= sample;
            idx_r <= idx_r + 1'b1;
            sum_r <= sum_r + {{vpe_pkg::AVG_SHIFT{1'b0}}, sample}
                - {{vpe_pkg::AVG_SHIFT{1'b0}}, buf_r[idx_r]};
        end
    end

    assign avg = sum_r[vpe_pkg::VW+vpe_pkg::AVG_SHIFT-1:vpe_pkg::AVG_SHIFT];
endmodule // vpe_avg

//--- vpe_top.sv
// Voltage protection element: one over/undervoltage stage with blocking.
// Assumes samples are synchronous to clock and already scaled to secondary volts.
`timescale 1ns/100ps

// Behaviour
// - One structure serves under- or overvoltage.
// - Phase-ground wiring: flags from phase voltages.
// - Phase-phase wiring: flags from line voltages.
// - Method selects fundamental or true RMS.
// - Sliding-average method, ten-minute window.
// - Mode code selects under or over.
// - Nominal is sec/root3 or sec.
// - Phase-phase wiring forces phase-phase measuring.
// - Current check only for undervoltage, when enabled.
// - All currents low blocks undervoltage.
// - Re-enable after delay once current returns.
// - External block suppresses undervoltage trip.
// - Fuse failure with supervision blocks undervoltage.
// - Loss-of-potential blocks undervoltage pickups below 0.03 Vn.
// - Pickup in one, two or three phases.
// - Overvoltage drops out at 97 percent earliest.
module vpe_top (
    input wire logic clock,
    input wire logic nrst,
    input wire vpe_pkg::vpe_cfg_t cfg,
    input wire logic [vpe_pkg::VW-1:0] vt_sec,
    input wire vpe_pkg::vpe_tri_t v_fund_pg,
    input wire vpe_pkg::vpe_tri_t v_rms_pg,
    input wire vpe_pkg::vpe_tri_t v_fund_pp,
    input wire vpe_pkg::vpe_tri_t v_rms_pp,
    input wire vpe_pkg::vpe_tri_t i_phase,
    input wire logic ext_block,
    input wire logic fuse_fail,
    output vpe_pkg::vpe_flags_t flags,
    output logic uv_blocked,
    output logic pot_loss_blocked
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rs1_r, rst_n;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Scale a per-unit pickup (Q8.8 of Vn) to volts.
    function automatic logic [vpe_pkg::VW-1:0] pu_to_v(input logic [vpe_pkg::VW-1:0] pu,
                                                        input logic [vpe_pkg::VW-1:0] vn);
        logic [31:0] p;
        p = 32'(pu) * 32'(vn);
        return p[23:8];
    endfunction

    function automatic logic [vpe_pkg::VW-1:0] pct_of(input logic [vpe_pkg::VW-1:0] v,
                                                       input logic [7:0] pct);
        logic [23:0] p;
        p = 24'(v) * 24'(pct);
        return 16'(p / 24'(vpe_pkg::PCT_FULL));
    endfunction

    // ------------------------------------------------------------------
    // Measurement selection
    // ------------------------------------------------------------------
    logic meas_pp;
    logic [vpe_pkg::VW-1:0] vn;
    vpe_pkg::vpe_tri_t v_inst;
    vpe_pkg::vpe_tri_t v_avg;
    vpe_pkg::vpe_tri_t v_sel;

    assign meas_pp = cfg.wiring_pp | cfg.meas_pp;
    assign vn = meas_pp ? vt_sec
        : 16'((32'(vt_sec) * 32'(vpe_pkg::INV_SQRT3_Q16)) >> 16);

    // The input set is chosen by wiring: phase or line voltages, same flag order.
    always_comb begin
        if (cfg.wiring_pp) begin
            v_inst = (cfg.meth == vpe_pkg::VPE_METH_FUND) ? v_fund_pp : v_rms_pp;
        end else begin
            v_inst = (cfg.meth == vpe_pkg::VPE_METH_FUND) ? v_fund_pg : v_rms_pg;
        end
    end

    // Averaging runs on v_inst: the RMS value under the average method, the fundamental under FUND; it only matters when selected.
    for (genvar g = 0; g < 3; g++) begin : g_avg
        vpe_avg u_avg (
            .clock(clock),
            .rst_n(rst_n),
            .sample(v_inst[g*vpe_pkg::VW +: vpe_pkg::VW]),
            .avg(v_avg[g*vpe_pkg::VW +: vpe_pkg::VW])
        );
    end

    assign v_sel = (cfg.meth == vpe_pkg::VPE_METH_AVG) ? v_avg : v_inst;

    // ------------------------------------------------------------------
    // Per-phase pickup with hysteresis
    // ------------------------------------------------------------------
    logic [vpe_pkg::VW-1:0] thr_v, drop_v;
    logic [7:0] ov_pct;
    logic [2:0] pick_r;
    logic is_uv;

    assign is_uv = (cfg.mode == vpe_pkg::VPE_MODE_UNDER);
    assign thr_v = pu_to_v(cfg.pickup_pu, vn);
    // Overvoltage dropout may not sit above 97 percent of the trip value.
    assign ov_pct = (cfg.dropout_pct > vpe_pkg::OV_DROP_PCT) ? vpe_pkg::OV_DROP_PCT
        : cfg.dropout_pct;
    assign drop_v = is_uv ? pct_of(thr_v, cfg.dropout_pct) : pct_of(thr_v, ov_pct);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pick_r <= 3'h0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (is_uv) begin
                    if (v_sel[p*vpe_pkg::VW +: vpe_pkg::VW] < thr_v) begin
                        pick_r[p] <= 1'b1;
                    end else if (v_sel[p*vpe_pkg::VW +: vpe_pkg::VW] > drop_v) begin
                        pick_r[p] <= 1'b0;
                    end
                end else begin
                    if (v_sel[p*vpe_pkg::VW +: vpe_pkg::VW] > thr_v) begin
                        pick_r[p] <= 1'b1;
                    end else if (v_sel[p*vpe_pkg::VW +: vpe_pkg::VW] < drop_v) begin
                        pick_r[p] <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Minimum-current supervision
    // ------------------------------------------------------------------
    vpe_pkg::vpe_imin_st_t st_r;
    logic [vpe_pkg::TW-1:0] imin_cnt_r;
    logic all_dead;

    assign all_dead = (i_phase.ph1 < cfg.imin_thr) && (i_phase.ph2 < cfg.imin_thr)
        && (i_phase.ph3 < cfg.imin_thr);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= vpe_pkg::VPE_ST_RUN;
            imin_cnt_r <= '0;
        end else if (!cfg.imin_en || !is_uv) begin
            st_r <= vpe_pkg::VPE_ST_RUN;
            imin_cnt_r <= '0;
        end else begin
            case (st_r)
                vpe_pkg::VPE_ST_RUN: begin
                    if (all_dead) begin
                        st_r <= vpe_pkg::VPE_ST_BLOCKED;
                    end
                end
                vpe_pkg::VPE_ST_BLOCKED: begin
                    imin_cnt_r <= '0;
                    if (!all_dead) begin
                        st_r <= vpe_pkg::VPE_ST_DELAY;
                    end
                end
                vpe_pkg::VPE_ST_DELAY: begin
                    if (all_dead) begin
                        st_r <= vpe_pkg::VPE_ST_BLOCKED;
                    end else if (imin_cnt_r + 1'b1 >= cfg.imin_dly_cyc) begin
                        st_r <= vpe_pkg::VPE_ST_RUN;
                    end else begin
                        imin_cnt_r <= imin_cnt_r + 1'b1;
                    end
                end
                default: begin
                    st_r <= vpe_pkg::VPE_ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Blocking and loss-of-potential
    // ------------------------------------------------------------------
    logic pot_loss_low, uv_block;
    // Pickup below 3 percent of Vn would always be masked by the monitor.
    assign pot_loss_low = (32'(cfg.pickup_pu) * 32'(vpe_pkg::POT_LOSS_DEN))
        < (32'(vpe_pkg::POT_LOSS_NUM) << 8);
    assign uv_block = is_uv && ((st_r != vpe_pkg::VPE_ST_RUN) || ext_block
        || (cfg.supv_en && fuse_fail) || pot_loss_low);

    // ------------------------------------------------------------------
    // Pickup logic and trip timer
    // ------------------------------------------------------------------
    logic [1:0] npick;
    logic pick_all;
    logic [vpe_pkg::TW-1:0] trip_cnt_r;

    assign npick = 2'(pick_r[0]) + 2'(pick_r[1]) + 2'(pick_r[2]);
    always_comb begin
        case (cfg.pick_logic)
            vpe_pkg::VPE_ANY_ONE: pick_all = (npick >= 2'd1);
            vpe_pkg::VPE_ANY_TWO: pick_all = (npick >= 2'd2);
            vpe_pkg::VPE_ALL_THREE: pick_all = (npick == 2'd3);
            default: pick_all = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trip_cnt_r <= '0;
        end else if (!pick_all || uv_block) begin
            trip_cnt_r <= '0;
        end else if (trip_cnt_r < cfg.trip_cyc) begin
            trip_cnt_r <= trip_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
            uv_blocked <= 1'b0;
            pot_loss_blocked <= 1'b0;
        end else begin
            flags.alarm <= uv_block ? 3'h0 : pick_r;
            flags.alarm_any <= pick_all && !uv_block;
            flags.trip_any <= pick_all && !uv_block && (trip_cnt_r >= cfg.trip_cyc);
            flags.trip <= (pick_all && !uv_block && (trip_cnt_r >= cfg.trip_cyc))
                ? pick_r : 3'h0;
            uv_blocked <= uv_block;
            pot_loss_blocked <= is_uv && pot_loss_low;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_trip_needs_pick: assert property (@(posedge clock) disable iff (!rst_n)
        flags.trip_any |-> $past(pick_all) && $past(trip_cnt_r) >= $past(cfg.trip_cyc))
        else $error("Trip without sustained pickup.");
    a_uv_ext_block: assert property (@(posedge clock) disable iff (!rst_n)
        (is_uv && ext_block) |=> !flags.trip_any)
        else $error("Undervoltage trip while externally blocked.");
    a_fuse_block: assert property (@(posedge clock) disable iff (!rst_n)
        (is_uv && cfg.supv_en && fuse_fail) |=> uv_blocked)
        else $error("Fuse failure did not block undervoltage.");
    a_imin_dead: assert property (@(posedge clock) disable iff (!rst_n)
        (is_uv && cfg.imin_en && all_dead && st_r == vpe_pkg::VPE_ST_RUN)
        |=> st_r == vpe_pkg::VPE_ST_BLOCKED)
        else $error("Dead currents did not block.");
    a_imin_only_uv: assert property (@(posedge clock) disable iff (!rst_n)
        (!is_uv || !cfg.imin_en) |=> st_r == vpe_pkg::VPE_ST_RUN)
        else $error("Current check active outside undervoltage.");
    a_imin_delay: assert property (@(posedge clock) disable iff (!rst_n)
        (st_r == vpe_pkg::VPE_ST_BLOCKED && !all_dead && cfg.imin_en && is_uv
        && cfg.imin_dly_cyc > 2) |=> ##1 st_r != vpe_pkg::VPE_ST_RUN)
        else $error("Re-enable came before the delay.");
    a_ov_drop: assert property (@(posedge clock) disable iff (!rst_n)
        !is_uv |-> drop_v <= pct_of(thr_v, vpe_pkg::OV_DROP_PCT))
        else $error("Overvoltage dropout above 97 percent.");
    a_pp_forced: assert property (@(posedge clock) disable iff (!rst_n)
        cfg.wiring_pp |-> meas_pp && vn == vt_sec)
        else $error("Phase-phase wiring did not force measuring mode.");
    a_all_three: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg.pick_logic == vpe_pkg::VPE_ALL_THREE && pick_r != 3'h7) |=> !flags.alarm_any)
        else $error("All-three logic picked up early.");

endmodule // vpe_top

//--- vpe_front.sv
// Far-side model: instrument transformer inputs and the trip relay contact.
// Assumes the bench sets primary levels just after a clock edge; measuring outputs follow at once, the relay contact one clock later.
`timescale 1ns/100ps
module vpe_front (
    input wire logic clock,
    input wire vpe_pkg::vpe_tri_t v_pg_set,
    input wire vpe_pkg::vpe_tri_t v_pp_set,
    input wire vpe_pkg::vpe_tri_t i_set,
    input wire logic [vpe_pkg::VW-1:0] rms_extra,
    input wire vpe_pkg::vpe_flags_t flags,
    output vpe_pkg::vpe_tri_t v_fund_pg,
    output vpe_pkg::vpe_tri_t v_rms_pg,
    output vpe_pkg::vpe_tri_t v_fund_pp,
    output vpe_pkg::vpe_tri_t v_rms_pp,
    output vpe_pkg::vpe_tri_t i_phase,
    output logic relay_closed
);
    // ------------------------------------------------------------------
    // Measuring inputs
    // ------------------------------------------------------------------
    // Harmonic content shows only in the true RMS value, so the two methods can differ.
    always_comb begin
        v_fund_pg = v_pg_set;
        v_fund_pp = v_pp_set;
        v_rms_pg.ph1 = v_pg_set.ph1 + rms_extra;
        v_rms_pg.ph2 = v_pg_set.ph2 + rms_extra;
        v_rms_pg.ph3 = v_pg_set.ph3 + rms_extra;
        v_rms_pp.ph1 = v_pp_set.ph1 + rms_extra;
        v_rms_pp.ph2 = v_pp_set.ph2 + rms_extra;
        v_rms_pp.ph3 = v_pp_set.ph3 + rms_extra;
        i_phase = i_set;
    end

    // ------------------------------------------------------------------
    // Trip relay
    // ------------------------------------------------------------------
    // The contact closes one clock after the trip level, like a driven coil.
    always_ff @(posedge clock) begin
        relay_closed <= flags.trip_any;
    end
endmodule // vpe_front

//--- tb_voltage_protection_element.sv
// Self-checking bench for the voltage protection element.
// Assumes vpe_top and vpe_front are compiled first; clock 100 MHz.
`timescale 1ns/100ps
module tb_voltage_protection_element;
    localparam logic [15:0] NOM = 16'h0E00;
    localparam logic [15:0] HI = 16'h1388;
    localparam logic [15:0] LO = 16'h07D0;
    logic clock;
    logic nrst;
    vpe_pkg::vpe_cfg_t cfg;
    vpe_pkg::vpe_tri_t vpg, vpp, iset, v_fund_pg, v_rms_pg, v_fund_pp, v_rms_pp, i_phase;
    logic [15:0] extra, vt;
    logic ext_block, fuse_fail, uv_blocked, pot_loss_blocked, relay_closed;
    vpe_pkg::vpe_flags_t flags;
    int errors, total_checks, n, k, need;

    vpe_front u_vpe_front (.clock(clock), .v_pg_set(vpg), .v_pp_set(vpp), .i_set(iset),
        .rms_extra(extra), .flags(flags), .v_fund_pg(v_fund_pg), .v_rms_pg(v_rms_pg),
        .v_fund_pp(v_fund_pp), .v_rms_pp(v_rms_pp), .i_phase(i_phase),
        .relay_closed(relay_closed));
    vpe_top u_vpe_top (.clock(clock), .nrst(nrst), .cfg(cfg), .vt_sec(vt),
        .v_fund_pg(v_fund_pg), .v_rms_pg(v_rms_pg), .v_fund_pp(v_fund_pp),
        .v_rms_pp(v_rms_pp), .i_phase(i_phase), .ext_block(ext_block),
        .fuse_fail(fuse_fail), .flags(flags), .uv_blocked(uv_blocked),
        .pot_loss_blocked(pot_loss_blocked));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits for trip (sel 0) or for the current block to lift (sel 1).
    task automatic wait_cond(input int sel, input int limit, output int c);
        for (c = 0; c < limit; c++) begin
            if (sel == 0 ? flags.trip_any === 1'b1 : uv_blocked === 1'b0) break;
            step(1);
        end
        if (c == limit) begin
            errors++;
            $display("wrong value wait %0d expected done seen timeout", sel);
            complete_run();
        end
    endtask

    task automatic set_pg(input int ph, input logic [15:0] v);
        if (ph == 1) vpg.ph1 = v;
        else if (ph == 2) vpg.ph2 = v;
        else vpg.ph3 = v;
    endtask

    // Healthy system; lets pickup and the trip timer clear before the next case.
    task automatic idle();
        vpg = {NOM, NOM, NOM};
        vpp = {NOM, NOM, NOM};
        iset = {3{16'h0200}};
        extra = 16'h0000;
        ext_block = 1'b0;
        fuse_fail = 1'b0;
        step(4);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        nrst = 1'b0;
        cfg = '0;
        cfg.mode = vpe_pkg::VPE_MODE_OVER;
        cfg.meth = vpe_pkg::VPE_METH_FUND;
        cfg.meas_pp = 1'b1;
        cfg.pick_logic = vpe_pkg::VPE_ANY_ONE;
        cfg.pickup_pu = 16'h0100;
        cfg.dropout_pct = 8'h61;
        // The trip delay stays longer than the supervision's reaction to a fuse failure.
        cfg.trip_cyc = 32'h0000_0014;
        vt = 16'h1000;
        cfg.imin_thr = 16'h0064;
        cfg.imin_dly_cyc = 32'h0000_0032;
        vpg = {NOM, NOM, NOM};
        vpp = {NOM, NOM, NOM};
        iset = {3{16'h0200}};
        extra = 16'h0000;
        ext_block = 1'b0;
        fuse_fail = 1'b0;
        step(10);
        nrst = 1'b1;
        step(3);
        idle();
        vpg.ph2 = HI;
        step(2);
        chk("alarm ph2", 4'h2, {1'b0, flags.alarm});
        step(10);
        chk("trip early", 4'h0, {3'h0, flags.trip_any});
        wait_cond(0, 20, n);
        chk("trip ph2", 4'h2, {1'b0, flags.trip});
        step(1);
        chk("relay", 4'h1, {3'h0, relay_closed});
        idle();
        vpg.ph1 = HI;
        step(15);
        vpg.ph1 = NOM;
        step(3);
        vpg.ph1 = HI;
        step(15);
        chk("trip restart", 4'h0, {3'h0, flags.trip_any});
        idle();
        // A 99 percent request must be capped, so 4000 still holds the pickup.
        cfg.dropout_pct = 8'h63;
        vpg.ph3 = HI;
        step(4);
        vpg.ph3 = 16'h0FA0;
        step(4);
        chk("hold 97pct", 4'h4, {1'b0, flags.alarm});
        vpg.ph3 = 16'h0F3C;
        step(4);
        chk("drop 95pct", 4'h0, {1'b0, flags.alarm});
        cfg.dropout_pct = 8'h61;
        // One, two and three phases needed in turn.
        for (need = 1; need <= 3; need++) begin
            cfg.pick_logic = vpe_pkg::vpe_logic_t'(need - 1);
            idle();
            for (k = 1; k <= 3; k++) begin
                set_pg(k, HI);
                step(4);
                chk("alarm_any logic", {3'h0, k >= need}, {3'h0, flags.alarm_any});
            end
        end
        cfg.pick_logic = vpe_pkg::VPE_ANY_ONE;
        idle();
        // Phases 2 and 3 sit below even the lower phase-ground pickup.
        cfg.meas_pp = 1'b0;
        vpg = {LO, LO, 16'h0BB8};
        step(4);
        chk("pg nominal", 4'h1, {1'b0, flags.alarm});
        cfg.meas_pp = 1'b1;
        step(4);
        chk("pp nominal", 4'h0, {1'b0, flags.alarm});
        cfg.wiring_pp = 1'b1;
        cfg.meas_pp = 1'b0;
        idle();
        vpp.ph1 = 16'h0BB8;
        vpg.ph3 = HI;
        step(4);
        chk("forced pp", 4'h0, {1'b0, flags.alarm});
        vpp.ph2 = HI;
        step(4);
        chk("line 23", 4'h2, {1'b0, flags.alarm});
        cfg.wiring_pp = 1'b0;
        cfg.meas_pp = 1'b1;
        cfg.meth = vpe_pkg::VPE_METH_RMS;
        idle();
        extra = 16'h0800;
        step(4);
        chk("rms", 4'h7, {1'b0, flags.alarm});
        cfg.meth = vpe_pkg::VPE_METH_FUND;
        step(4);
        chk("fund", 4'h0, {1'b0, flags.alarm});
        cfg.mode = vpe_pkg::VPE_MODE_UNDER;
        cfg.pickup_pu = 16'h00C0;
        idle();
        chk("under idle", 4'h0, {1'b0, flags.alarm});
        vpg.ph1 = LO;
        step(4);
        chk("under ph1", 4'h1, {1'b0, flags.alarm});
        ext_block = 1'b1;
        step(2);
        chk("ext block", 4'h0, {1'b0, flags.alarm});
        ext_block = 1'b0;
        fuse_fail = 1'b1;
        step(4);
        chk("fuse unsupervised", 4'h1, {1'b0, flags.alarm});
        cfg.supv_en = 1'b1;
        step(4);
        chk("fuse supervised", 4'h0, {1'b0, flags.alarm});
        fuse_fail = 1'b0;
        vpg.ph1 = 16'h0000;
        cfg.pickup_pu = 16'h0007;
        step(4);
        chk("pot loss low", 4'h1, {3'h0, pot_loss_blocked});
        chk("pot loss alarm", 4'h0, {1'b0, flags.alarm});
        cfg.pickup_pu = 16'h0008;
        step(4);
        chk("pot loss clear", 4'h0, {3'h0, pot_loss_blocked});
        chk("pot loss alarm", 4'h1, {1'b0, flags.alarm});
        cfg.pickup_pu = 16'h00C0;
        cfg.imin_en = 1'b1;
        idle();
        vpg.ph1 = LO;
        iset = '0;
        step(4);
        chk("imin block", 4'h1, {3'h0, uv_blocked});
        chk("imin alarm", 4'h0, {1'b0, flags.alarm});
        iset.ph2 = 16'h00C8;
        step(20);
        chk("imin delay", 4'h1, {3'h0, uv_blocked});
        wait_cond(1, 60, n);
        // Twenty cycles have passed already; the block may not lift before the 50-cycle delay.
        chk("imin delay long", 4'h1, {3'h0, n >= 30});
        step(4);
        chk("imin release", 4'h1, {1'b0, flags.alarm});
        iset = '0;
        cfg.imin_en = 1'b0;
        step(4);
        chk("imin off", 4'h1, {1'b0, flags.alarm});
        cfg.imin_en = 1'b1;
        cfg.mode = vpe_pkg::VPE_MODE_OVER;
        cfg.pickup_pu = 16'h0100;
        vpg.ph1 = HI;
        step(4);
        chk("imin over", 4'h1, {1'b0, flags.alarm});
        // A ten-minute average cannot follow a step within a few cycles.
        cfg.meth = vpe_pkg::VPE_METH_AVG;
        step(4);
        chk("avg slow", 4'h0, {1'b0, flags.alarm});
        complete_run();
    end
endmodule // tb_voltage_protection_element
